/* File: include/itam_pkg.sv */
`default_nettype none
package itam_pkg;
   // Register byte offsets
   localparam int unsigned AXI_AW        = 8;
   localparam logic [7:0]  OFS_OWN0      = 8'h04;
   localparam logic [7:0]  OFS_TOC       = 8'h14;
   localparam logic [7:0]  OFS_OWN1      = 8'h18;
   localparam logic [7:0]  OFS_OWN2      = 8'h1c;
   localparam logic [7:0]  OFS_OWN3      = 8'h20;
   localparam logic [7:0]  OFS_MSK0      = 8'h24;
   localparam logic [7:0]  OFS_MSK1      = 8'h28;
   localparam logic [7:0]  OFS_MSK2      = 8'h2c;
   localparam logic [7:0]  OFS_MSK3      = 8'h30;
   localparam logic [7:0]  OFS_EVT       = 8'h38;
   localparam logic [7:0]  OFS_IST       = 8'h40;
   localparam logic [7:0]  OFS_ICL       = 8'h44;
   localparam logic [7:0]  OFS_IEN       = 8'h48;
   // Field positions
   localparam int unsigned TOC_FLAG_BIT  = 0;
   localparam int unsigned TOC_W         = 3;
   localparam int unsigned GC_BIT        = 0;
   localparam int unsigned ADR_MSB       = 7;
   localparam int unsigned ADR_LSB       = 1;
   localparam int unsigned EVT_FLAG_BIT  = 0;
   localparam int unsigned EVT_CODE_LSB  = 8;
   localparam int unsigned IRQ_TO        = 0;
   localparam int unsigned IRQ_HIT       = 1;
   localparam int unsigned IRQ_SE        = 2;
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned SLOTS         = 4;
   // Reset values and codes
   localparam logic [7:0]  REG_RST       = 8'h00;
   localparam logic [7:0]  NO_EVENT_CODE = 8'hf8;
   localparam logic [6:0]  GC_ADDR       = 7'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // Timeout counter shape
   localparam int unsigned CNT_W         = 14;
   localparam int unsigned PRE_DIV       = 4;

   // Timeout control register layout
   typedef struct packed {
      logic enable;
      logic prescale;
      logic flag;
   } itam_toc_s;

   // Registered address recognition result
   typedef struct packed {
      logic       hit;
      logic       general_call;
      logic [1:0] slot;
   } itam_hit_s;
endpackage
`default_nettype wire

/* File: logic/itam_timeout.sv */
`default_nettype none
module itam_timeout #(
   parameter int unsigned CNT_W   = itam_pkg::CNT_W,
   parameter int unsigned PRE_DIV = itam_pkg::PRE_DIV
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Control
   input  wire logic             enable,
   input  wire logic             prescale,
   input  wire logic             serial_event,
   // Status
   output logic [CNT_W-1:0]      count,
   output logic                  overflow
);
   localparam int unsigned PRE_W = $clog2(PRE_DIV);

   logic [PRE_W-1:0] prescale_count;

   // Run gating and count tick
   wire run      = enable & ~serial_event;
   wire pre_last = prescale_count == PRE_W'(PRE_DIV - 1);
   wire tick     = run & (~prescale | pre_last);
   wire at_max   = count == {CNT_W{1'b1}};

   // Prescaler, counter and overflow pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         prescale_count <= '0;
         count          <= '0;
         overflow       <= 1'b0;
      end else begin
         prescale_count <= pre_last ? '0 : prescale_count + 1'b1;
         count          <= tick ? count + 1'b1 : count;
         overflow       <= tick & at_max;
      end
   end
endmodule // itam_timeout
`default_nettype wire

/* File: logic/itam_addr_match.sv */
`default_nettype none
module itam_addr_match (
   // Programmed slot
   input  wire logic [7:0] own_address,
   input  wire logic [7:0] address_mask,
   // Received address
   input  wire logic [6:0] rx_address,
   // Result
   output logic            own_hit,
   output logic            gc_hit
);
   // Masked compare and general call detect
   wire [6:0] diff = (rx_address ^ own_address[itam_pkg::ADR_MSB:itam_pkg::ADR_LSB])
                     & ~address_mask[itam_pkg::ADR_MSB:itam_pkg::ADR_LSB];
   wire       is_gc = rx_address == itam_pkg::GC_ADDR;
   assign own_hit = (diff == 7'h00) & ~is_gc;
   assign gc_hit  = is_gc & own_address[itam_pkg::GC_BIT];
endmodule // itam_addr_match
`default_nettype wire

/* File: logic/itam_top.sv */
// What this block does
// - Enable bit runs 14-bit counter while serial event flag clear
// - Serial event flag resets counter; restart after clear
// - Prescale bit divides counter input by four
// - Timeout sets flag bit, may interrupt
// - Own addresses ignored in master mode
// - Slave responds to any of four addresses
// - Address bit zero enables general call
// - Serial event flag set per state, except F8
// - Mask bit one makes address bit don't-care
`default_nettype none
module itam_top (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [itam_pkg::AXI_AW-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   // AXI4-Lite write response
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   output logic [1:0]                      s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   input  wire logic [itam_pkg::AXI_AW-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   // Controller side inputs
   input  wire logic                       master_mode,
   input  wire logic                       state_entered,
   input  wire logic [7:0]                 bus_state_code,
   input  wire logic                       rx_address_valid,
   input  wire logic [6:0]                 rx_address,
   // Controller side outputs
   output logic                            serial_event_flag,
   output logic                            timeout_flag,
   output itam_pkg::itam_hit_s             address_result,
   // Interrupt
   output logic                            irq
);
   // Register state
   logic [7:0]                      own_address [itam_pkg::SLOTS];
   logic [7:0]                      address_mask [itam_pkg::SLOTS];
   itam_pkg::itam_toc_s             timeout_control;
   logic [7:0]                      state_code;
   logic [itam_pkg::IRQ_W-1:0]      irq_status;
   logic [itam_pkg::IRQ_W-1:0]      irq_enable;

   // Write channel holding state
   logic                            aw_held;
   logic [itam_pkg::AXI_AW-1:0]     aw_addr;
   logic                            w_held;
   logic [31:0]                     w_data;
   logic                            w_low_lane;

   // Handshakes
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire   aw_take       = s_axi_awvalid & s_axi_awready;
   wire   w_take        = s_axi_wvalid & s_axi_wready;
   wire   ar_take       = s_axi_arvalid & s_axi_arready;
   wire   do_write      = aw_held & w_held & ~s_axi_bvalid;

   // Write address decode
   wire wr_toc  = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_TOC);
   wire wr_evt  = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_EVT);
   wire wr_icl  = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_ICL);
   wire wr_ien  = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_IEN);
   wire [itam_pkg::SLOTS-1:0] wr_own;
   wire [itam_pkg::SLOTS-1:0] wr_msk;
   assign wr_own[0] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_OWN0);
   assign wr_own[1] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_OWN1);
   assign wr_own[2] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_OWN2);
   assign wr_own[3] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_OWN3);
   assign wr_msk[0] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_MSK0);
   assign wr_msk[1] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_MSK1);
   assign wr_msk[2] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_MSK2);
   assign wr_msk[3] = do_write & w_low_lane & (aw_addr == itam_pkg::OFS_MSK3);

   // Mapped check for write response
   wire wr_mapped = (aw_addr == itam_pkg::OFS_TOC) | (aw_addr == itam_pkg::OFS_EVT)
                  | (aw_addr == itam_pkg::OFS_ICL) | (aw_addr == itam_pkg::OFS_IEN)
                  | (aw_addr == itam_pkg::OFS_OWN0) | (aw_addr == itam_pkg::OFS_OWN1)
                  | (aw_addr == itam_pkg::OFS_OWN2) | (aw_addr == itam_pkg::OFS_OWN3)
                  | (aw_addr == itam_pkg::OFS_MSK0) | (aw_addr == itam_pkg::OFS_MSK1)
                  | (aw_addr == itam_pkg::OFS_MSK2) | (aw_addr == itam_pkg::OFS_MSK3)
                  | (aw_addr == itam_pkg::OFS_IST);

   // Write-one-to-clear requests; hardware sets win below
   wire clr_timeout = wr_toc & w_data[itam_pkg::TOC_FLAG_BIT];
   wire clr_event   = wr_evt & w_data[itam_pkg::EVT_FLAG_BIT];
   wire [itam_pkg::IRQ_W-1:0] clr_status = wr_icl ? w_data[itam_pkg::IRQ_W-1:0] : '0;

   // Write channel capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         w_held       <= 1'b0;
         w_data       <= '0;
         w_low_lane   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= itam_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held     <= 1'b1;
            w_data     <= s_axi_wdata;
            w_low_lane <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? itam_pkg::RESP_OKAY : itam_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Own address and mask storage
   always_ff @(posedge aclk) begin
      for (int i = 0; i < itam_pkg::SLOTS; i++) begin
         if (!aresetn) begin
            own_address[i]  <= itam_pkg::REG_RST;
            address_mask[i] <= itam_pkg::REG_RST;
         end else begin
            if (wr_own[i]) begin
               own_address[i] <= w_data[7:0];
            end
            if (wr_msk[i]) begin
               address_mask[i] <= {w_data[itam_pkg::ADR_MSB:itam_pkg::ADR_LSB], 1'b0};
            end
         end
      end
   end

   // Timeout counter
   logic timeout_overflow;
   itam_timeout #(
      .CNT_W   (itam_pkg::CNT_W),
      .PRE_DIV (itam_pkg::PRE_DIV)
   ) u_timeout (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .enable       (timeout_control.enable),
      .prescale     (timeout_control.prescale),
      .serial_event (serial_event_flag),
      .count        (),
      .overflow     (timeout_overflow)
   );

   // Timeout control register, flag set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_control <= itam_pkg::itam_toc_s'(itam_pkg::REG_RST[itam_pkg::TOC_W-1:0]);
      end else begin
         if (wr_toc) begin
            {timeout_control.enable, timeout_control.prescale} <= w_data[itam_pkg::TOC_W-1:itam_pkg::TOC_FLAG_BIT+1];
         end
         if (timeout_overflow) begin
            timeout_control.flag <= 1'b1;
         end else if (clr_timeout) begin
            timeout_control.flag <= 1'b0;
         end
      end
   end
   assign timeout_flag = timeout_control.flag;

   // Serial event flag and captured state code
   wire state_event = state_entered & (bus_state_code != itam_pkg::NO_EVENT_CODE);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_event_flag <= 1'b0;
         state_code        <= itam_pkg::NO_EVENT_CODE;
      end else begin
         if (state_entered) begin
            state_code <= bus_state_code;
         end
         if (state_event) begin
            serial_event_flag <= 1'b1;
         end else if (clr_event) begin
            serial_event_flag <= 1'b0;
         end
      end
   end

   // Four address comparators
   wire [itam_pkg::SLOTS-1:0] own_hit;
   wire [itam_pkg::SLOTS-1:0] gc_hit;
   for (genvar g = 0; g < itam_pkg::SLOTS; g++) begin : g_slot
      itam_addr_match u_match (
         .own_address  (own_address[g]),
         .address_mask (address_mask[g]),
         .rx_address   (rx_address),
         .own_hit      (own_hit[g]),
         .gc_hit       (gc_hit[g])
      );
   end

   // Lowest slot wins; master mode suppresses recognition
   wire       slave_look = rx_address_valid & ~master_mode;
   wire       any_own    = |own_hit;
   wire       any_gc     = |gc_hit;
   wire [3:0] sel_vec    = any_own ? own_hit : gc_hit;
   wire [1:0] sel_slot   = sel_vec[0] ? 2'h0 : sel_vec[1] ? 2'h1 : sel_vec[2] ? 2'h2 : 2'h3;
   wire       match_now  = slave_look & (any_own | any_gc);

   // Registered recognition result, one-cycle hit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         address_result <= '0;
      end else begin
         address_result.hit <= match_now;
         if (match_now) begin
            address_result.general_call <= ~any_own;
            address_result.slot         <= sel_slot;
         end
      end
   end

   // Interrupt status, enable and output
   wire [itam_pkg::IRQ_W-1:0] irq_set;
   assign irq_set[itam_pkg::IRQ_TO]  = timeout_overflow;
   assign irq_set[itam_pkg::IRQ_HIT] = match_now;
   assign irq_set[itam_pkg::IRQ_SE]  = state_event;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
         irq_enable <= '0;
      end else begin
         irq_status <= irq_set | (irq_status & ~clr_status);
         if (wr_ien) begin
            irq_enable <= w_data[itam_pkg::IRQ_W-1:0];
         end
      end
   end
   assign irq = |(irq_status & irq_enable);

   // Read data selection
   wire [itam_pkg::AXI_AW-1:0] ra = s_axi_araddr;
   wire        rd_ist = ra == itam_pkg::OFS_IST;
   wire        rd_ien = ra == itam_pkg::OFS_IEN;
   wire        rd_icl = ra == itam_pkg::OFS_ICL;
   wire [31:0] rd_evt = {16'h0000, state_code, 7'h00, serial_event_flag};
   wire [31:0] rd_data =
        (ra == itam_pkg::OFS_OWN0) ? {24'h000000, own_address[0]}  :
        (ra == itam_pkg::OFS_OWN1) ? {24'h000000, own_address[1]}  :
        (ra == itam_pkg::OFS_OWN2) ? {24'h000000, own_address[2]}  :
        (ra == itam_pkg::OFS_OWN3) ? {24'h000000, own_address[3]}  :
        (ra == itam_pkg::OFS_MSK0) ? {24'h000000, address_mask[0]} :
        (ra == itam_pkg::OFS_MSK1) ? {24'h000000, address_mask[1]} :
        (ra == itam_pkg::OFS_MSK2) ? {24'h000000, address_mask[2]} :
        (ra == itam_pkg::OFS_MSK3) ? {24'h000000, address_mask[3]} :
        (ra == itam_pkg::OFS_TOC)  ? {29'h00000000, timeout_control} :
        (ra == itam_pkg::OFS_EVT)  ? rd_evt :
        rd_ist                     ? {29'h00000000, irq_status} :
        rd_ien                     ? {29'h00000000, irq_enable} : 32'h00000000;
   wire rd_mapped = (ra == itam_pkg::OFS_OWN0) | (ra == itam_pkg::OFS_OWN1)
                  | (ra == itam_pkg::OFS_OWN2) | (ra == itam_pkg::OFS_OWN3)
                  | (ra == itam_pkg::OFS_MSK0) | (ra == itam_pkg::OFS_MSK1)
                  | (ra == itam_pkg::OFS_MSK2) | (ra == itam_pkg::OFS_MSK3)
                  | (ra == itam_pkg::OFS_TOC) | (ra == itam_pkg::OFS_EVT)
                  | rd_ist | rd_ien | rd_icl;

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= itam_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_mapped ? itam_pkg::RESP_OKAY : itam_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // itam_top
`default_nettype wire

/* File: dv/itam_monitor.sv */
`default_nettype none
module itam_monitor (
   // Clock and reset
   input wire logic                aclk,
   input wire logic                aresetn,
   // Register bus handshakes
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   // Controller side
   input wire logic                master_mode,
   input wire logic                state_entered,
   input wire logic [7:0]          bus_state_code,
   input wire logic                rx_address_valid,
   input wire logic [6:0]          rx_address,
   input wire logic                serial_event_flag,
   input wire logic                timeout_flag,
   input wire itam_pkg::itam_hit_s address_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] quiet_cnt;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Cycles since the serial event flag was last seen set
   always_ff @(posedge aclk) begin
      if (!aresetn || serial_event_flag) begin
         quiet_cnt <= 16'h0000;
      end else if (quiet_cnt != 16'hffff) begin
         quiet_cnt <= quiet_cnt + 16'h0001;
      end
   end
   // Serial event flag and the no-interrupt code
   chk_se_set: assert property (state_entered && bus_state_code != 8'hf8 |=> serial_event_flag)
      else $error("serial event flag not set on new state");
   chk_se_none: assert property (state_entered && bus_state_code == 8'hf8 && !serial_event_flag
      |=> !serial_event_flag)
      else $error("serial event flag set on idle code");
   // Address recognition
   chk_master_quiet: assert property (rx_address_valid && master_mode |=> !address_result.hit)
      else $error("address hit while bus master");
   chk_hit_cause: assert property (address_result.hit |-> $past(rx_address_valid && !master_mode))
      else $error("address hit without slave address");
   chk_gc_zero: assert property (address_result.hit && address_result.general_call
      |-> $past(rx_address) == 7'h00)
      else $error("general call hit on nonzero address");
   chk_own_nonzero: assert property (address_result.hit && !address_result.general_call
      |-> $past(rx_address) != 7'h00)
      else $error("own hit on all-zero address");
   // Timeout flag only after a full count, cleared only by a write
   chk_flag_quiet: assert property ($rose(timeout_flag) |-> quiet_cnt >= 16'h4000)
      else $error("timeout flag set too early");
   chk_tf_swclear: assert property ($fell(timeout_flag) |-> s_axi_bvalid)
      else $error("timeout flag fell without a write");
   // Bus answers
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   // Main scenarios
   cov_gc: cover property (address_result.hit && address_result.general_call);
   cov_to: cover property ($rose(timeout_flag));
   cov_se: cover property ($fell(serial_event_flag));
endmodule // itam_monitor

bind itam_top itam_monitor i_mon (
   .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready,
   .master_mode, .state_entered, .bus_state_code, .rx_address_valid, .rx_address,
   .serial_event_flag, .timeout_flag, .address_result
);
`default_nettype wire

/* File: dv/itam_peer.sv */
`default_nettype none
module itam_peer (
   // Clock
   input wire logic  aclk,
   // Controller side
   output logic       master_mode,
   output logic       state_entered,
   output logic [7:0] bus_state_code,
   output logic       rx_address_valid,
   output logic [6:0] rx_address
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus
   initial begin
      master_mode = 1'b0;
      state_entered = 1'b0;
      bus_state_code = 8'h00;
      rx_address_valid = 1'b0;
      rx_address = 7'h00;
   end
   // New bus state; code scrambled once the pulse ends
   task automatic send_state(input logic [7:0] code);
      @(posedge aclk);
      state_entered <= 1'b1;
      bus_state_code <= code;
      @(posedge aclk);
      state_entered <= 1'b0;
      bus_state_code <= ~code;
   endtask
   // Received slave address, in master or slave role
   task automatic send_addr(input logic [6:0] a, input logic mst);
      @(posedge aclk);
      rx_address_valid <= 1'b1;
      rx_address <= a;
      master_mode <= mst;
      @(posedge aclk);
      rx_address_valid <= 1'b0;
      rx_address <= ~a;
      master_mode <= 1'b0;
   endtask
endmodule // itam_peer
`default_nettype wire

/* File: dv/itam_tb_top.sv */
`default_nettype none
module itam_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                s_axi_rready, master_mode, state_entered, rx_address_valid;
   logic                serial_event_flag, timeout_flag, irq;
   logic [7:0]          s_axi_awaddr, s_axi_araddr, bus_state_code;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic [6:0]          rx_address;
   itam_pkg::itam_hit_s address_result;
   int                  fail_count, checks_done;

   itam_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .master_mode, .state_entered, .bus_state_code, .rx_address_valid, .rx_address,
      .serial_event_flag, .timeout_flag, .address_result, .irq);
   itam_peer i_peer (.aclk, .master_mode, .state_entered, .bus_state_code, .rx_address_valid,
      .rx_address);

   // Clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic give_up();
      fail_count++;
      $display("[FAIL] wait expected done seen timeout");
      finish_test();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Register bus write; response taken late on purpose
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n == 2) s_axi_bready <= 1'b1;
         if (s_axi_bvalid && s_axi_bready) break;
      end
      if (n == 40) give_up();
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   // Register bus read with data and response compare
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 40) give_up();
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   // Reset values, read-back, read-only and unmapped places
   task automatic t_regs();
      logic [7:0] own [4] = '{itam_pkg::OFS_OWN0, itam_pkg::OFS_OWN1, itam_pkg::OFS_OWN2, itam_pkg::OFS_OWN3};
      rd_chk(itam_pkg::OFS_TOC, 32'h0, 2'h0);
      foreach (own[i]) begin
         rd_chk(own[i], 32'h0, 2'h0);
         wr(own[i], {24'hffffff, 8'h5a ^ 8'(i)}, 2'h0);
         rd_chk(own[i], {24'h0, 8'h5a ^ 8'(i)}, 2'h0);
      end
      wr(itam_pkg::OFS_TOC, 32'h6, 2'h0);
      rd_chk(itam_pkg::OFS_TOC, 32'h6, 2'h0);
      wr(itam_pkg::OFS_TOC, 32'h0, 2'h0);
      wr(itam_pkg::OFS_IST, 32'h7, 2'h0);
      rd_chk(itam_pkg::OFS_IST, 32'h0, 2'h0);
      wr(8'h00, 32'h1, 2'h2);
      rd_chk(8'h00, 32'h0, 2'h2);
      $display("test t_regs done");
   endtask

   // One received address and its registered result
   task automatic try_addr(input logic [6:0] a, input logic m, input logic [3:0] e);
      i_peer.send_addr(a, m);
      #1;
      chk("address_result", e[3] ? e : 4'h0, e[3] ? address_result : {address_result.hit, 3'h0});
   endtask
   task automatic t_match();
      wr(itam_pkg::OFS_OWN0, 32'h11, 2'h0);
      wr(itam_pkg::OFS_OWN1, 32'h54, 2'h0);
      wr(itam_pkg::OFS_OWN2, 32'ha1, 2'h0);
      wr(itam_pkg::OFS_OWN3, 32'ha0, 2'h0);
      wr(itam_pkg::OFS_MSK3, 32'h06, 2'h0);
      wr(itam_pkg::OFS_IEN, 32'h2, 2'h0);
      try_addr(7'h08, 1'b0, 4'b1000);
      try_addr(7'h2a, 1'b0, 4'b1001);
      try_addr(7'h50, 1'b0, 4'b1010);
      try_addr(7'h53, 1'b0, 4'b1011);
      try_addr(7'h2b, 1'b0, 4'b0000);
      try_addr(7'h00, 1'b0, 4'b1100);
      try_addr(7'h2a, 1'b1, 4'b0000);
      chk("irq", 32'h1, {31'h0, irq});
      wr(itam_pkg::OFS_ICL, 32'h2, 2'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(itam_pkg::OFS_OWN0, 32'h10, 2'h0);
      try_addr(7'h00, 1'b0, 4'b1110);
      wr(itam_pkg::OFS_OWN2, 32'ha0, 2'h0);
      try_addr(7'h00, 1'b0, 4'b0000);
      wr(itam_pkg::OFS_ICL, 32'h2, 2'h0);
      $display("test t_match done");
   endtask

   // Serial event flag, its code and its masked interrupt
   task automatic t_event();
      i_peer.send_state(8'hf8);
      #1 chk("serial_event_flag", 32'h0, {31'h0, serial_event_flag});
      i_peer.send_state(8'h08);
      #1 chk("serial_event_flag", 32'h1, {31'h0, serial_event_flag});
      chk("irq", 32'h0, {31'h0, irq});
      wr(itam_pkg::OFS_IEN, 32'h4, 2'h0);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk(itam_pkg::OFS_EVT, 32'h0801, 2'h0);
      wr(itam_pkg::OFS_EVT, 32'h1, 2'h0);
      wr(itam_pkg::OFS_ICL, 32'h4, 2'h0);
      chk("serial_event_flag", 32'h0, {31'h0, serial_event_flag});
      chk("irq", 32'h0, {31'h0, irq});
      $display("test t_event done");
   endtask

   // Cycles from the end of a write until the timeout flag shows
   task automatic wait_flag(input int e);
      int n;
      for (n = 1; n < 70000; n++) begin
         @(posedge aclk);
         if (timeout_flag === 1'b1) break;
      end
      if (n == 70000) give_up();
      chk("timeout cycles in range", 32'h1, {31'h0, n >= e - 1 && n <= e + 1});
   endtask
   // Count, restart on serial event, prescale and flag clear
   task automatic t_timeout();
      wr(itam_pkg::OFS_IEN, 32'h1, 2'h0);
      wr(itam_pkg::OFS_TOC, 32'h4, 2'h0);
      repeat (3000) @(posedge aclk);
      i_peer.send_state(8'h20);
      repeat (20) @(posedge aclk);
      chk("timeout_flag", 32'h0, {31'h0, timeout_flag});
      wr(itam_pkg::OFS_EVT, 32'h1, 2'h0);
      wait_flag(16384);
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk(itam_pkg::OFS_TOC, 32'h5, 2'h0);
      wr(itam_pkg::OFS_TOC, 32'h1, 2'h0);
      chk("timeout_flag", 32'h0, {31'h0, timeout_flag});
      wr(itam_pkg::OFS_TOC, 32'h6, 2'h0);
      wait_flag(65536);
      wr(itam_pkg::OFS_TOC, 32'h1, 2'h0);
      wr(itam_pkg::OFS_ICL, 32'h1, 2'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test t_timeout done");
   endtask

   // Main sequence
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
      s_axi_wdata = 32'h0;
      fail_count = 0;
      checks_done = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_match();
      t_event();
      t_timeout();
      finish_test();
   end
endmodule // itam_tb_top
`default_nettype wire
